// ===== include/tlm_cfg.svh
`ifndef TLM_CFG_SVH
`define TLM_CFG_SVH
`define TLM_NCH 4
`define TLM_CLK_MHZ 200
`define TLM_FAST_PERIOD_US 15625
`define TLM_RATE_MAX 4'ha
`define TLM_RATE_RST 4'h6
`define TLM_A_CFG 8'h00
`define TLM_A_RATE 8'h04
`define TLM_A_ONESHOT 8'h08
`define TLM_A_STATUS 8'h0c
`define TLM_A_CMASK 8'h10
`define TLM_A_HYST 8'h14
`define TLM_A_CONS 8'h18
`define TLM_A_TEMP 8'h20
`define TLM_A_LIM 8'h30
`define TLM_CFG_STBY 0
`define TLM_CFG_CMP 1
`define TLM_CFG_MASK 2
`define TLM_CFG_AVGDIS 3
`define TLM_CONS_ALR_LSB 0
`define TLM_CONS_THM_LSB 4
`define TLM_CFG_RST 8'h00
`define TLM_HIGH_RST 8'h55
`define TLM_LOW_RST 8'h00
`define TLM_THERM_RST 8'h55
`define TLM_HYST_RST 8'h0a
`define TLM_CONS_RST 8'h11
`define TLM_AVG_1X 3'h3
`endif

// ===== include/tlm_pkg.sv
package tlm_pkg;
   typedef logic [10:0] temp_t;
   typedef logic [1:0]  chan_t;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT, SEQ_EVAL} seq_state_e;
   typedef struct packed
   {
      logic [7:0] therm;
      logic [7:0] low;
      logic [7:0] high;
   } limits_s;
   typedef struct packed
   {
      chan_t      chan;
      logic [2:0] avg;
      logic       beta;
   } conv_req_s;
   typedef struct packed
   {
      temp_t data;
      logic  fault;
      logic  cpu_diode;
   } conv_rsp_s;
endpackage

// ===== core/temp_limit_alert_monitor.sv
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tlm_cfg.svh"
module temp_limit_alert_monitor
#(
   parameter int unsigned FAST_PERIOD_CYC = `TLM_FAST_PERIOD_US * `TLM_CLK_MHZ
)
(
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic [7:0]        address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   input  wire logic [3:0]        byteenable,
   output logic [31:0]            readdata,
   output logic                   waitrequest,
   output logic                   conv_start,
   output tlm_pkg::conv_req_s     conv_req,
   input  wire logic              conv_done,
   input  wire tlm_pkg::conv_rsp_s conv_rsp,
   output logic                   alert_n_out,
   output logic                   alert_n_oe,
   output logic                   therm_n_out,
   output logic                   therm_n_oe
);
   localparam int NCH = `TLM_NCH;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
      return a[7:2] == base[7:2];
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
            r[b*8 +: 8] = wd[b*8 +: 8];
      end
      return r;
   endfunction

   function automatic logic [2:0] avg_code(input logic [3:0] r, input logic dis);
      logic [2:0] c;
      c = 3'h0;
      case (r)
         4'h0, 4'h1, 4'h2, 4'h3: c = 3'h7;
         4'h4:    c = 3'h6;
         4'h5:    c = 3'h5;
         4'h6:    c = 3'h4;
         4'h7:    c = 3'h3;
         4'h8:    c = 3'h2;
         4'h9:    c = 3'h1;
         default: c = 3'h0;
      endcase
      if (dis && r <= 4'h7)
         c = `TLM_AVG_1X;
      return c;
   endfunction

   logic [7:0]              cfg_q;
   logic [3:0]              rate_q;
   logic [NCH-1:0]          cmask_q;
   logic [7:0]              hyst_q;
   logic [7:0]              cons_q;
   tlm_pkg::limits_s        lim_q [NCH];
   tlm_pkg::temp_t          temp_q [NCH];
   logic [NCH-1:0]          flt_q;
   logic [NCH-1:0]          cpu_q;
   logic [3:0]              acnt_q [NCH];
   logic [3:0]              tcnt_q [NCH];
   logic [NCH-1:0]          hi_st_q;
   logic [NCH-1:0]          lo_st_q;
   logic [NCH-1:0]          flt_st_q;
   logic [NCH-1:0]          thm_st_q;
   logic [NCH-1:0]          hi_rel_q;
   logic [NCH-1:0]          thm_rel_q;
   logic [NCH-1:0]          aq_w;
   logic [NCH-1:0]          hq_w;
   logic [NCH-1:0]          tq_w;
   logic                    cmp_alert_q;
   logic                    therm_act_q;
   tlm_pkg::seq_state_e     st_q;
   tlm_pkg::chan_t          ch_q;
   logic                    os_pend_q;
   logic                    os_run_q;
   logic [32:0]             tmr_q;
   logic                    tick_q;
   logic [31:0]             rd_d;

   wire stby   = cfg_q[`TLM_CFG_STBY];
   wire cmp    = cfg_q[`TLM_CFG_CMP];
   wire acc    = (read || write) && waitrequest;
   wire wr_en  = write && !waitrequest;
   wire abort  = stby && !os_run_q;
   wire [3:0] rate_eff = (rate_q > `TLM_RATE_MAX) ? `TLM_RATE_MAX : rate_q;
   wire [32:0] period  = 33'(FAST_PERIOD_CYC) << (`TLM_RATE_MAX - rate_eff);
   wire [3:0] alr_need = cons_q[`TLM_CONS_ALR_LSB +: 4];
   wire [3:0] thm_need = cons_q[`TLM_CONS_THM_LSB +: 4];

   // Bus slave: one wait cycle, read data lands on the release edge, write data one edge later.
   always_ff @(posedge clk)
   begin
      if (srst)
         waitrequest <= 1'b1;
      else
         waitrequest <= !acc;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         readdata <= 32'h0;
      else if (acc && read)
         readdata <= rd_d;
   end

   always_comb
   begin
      rd_d = 32'h0;
      if (hit(address, `TLM_A_CFG))
         rd_d = {24'h0, cfg_q};
      else if (hit(address, `TLM_A_RATE))
         rd_d = {28'h0, rate_q};
      else if (hit(address, `TLM_A_STATUS))
         rd_d = {15'h0, st_q != tlm_pkg::SEQ_IDLE, thm_st_q, flt_st_q, lo_st_q, hi_st_q};
      else if (hit(address, `TLM_A_CMASK))
         rd_d = {28'h0, cmask_q};
      else if (hit(address, `TLM_A_HYST))
         rd_d = {24'h0, hyst_q};
      else if (hit(address, `TLM_A_CONS))
         rd_d = {24'h0, cons_q};
      else if (address[7:4] == `TLM_A_TEMP >> 4)
         rd_d = {16'h0, temp_q[address[3:2]][10:3], temp_q[address[3:2]][2:0], 5'h0};
      else if (address[7:4] == `TLM_A_LIM >> 4)
         rd_d = {8'h0, lim_q[address[3:2]]};
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cfg_q   <= `TLM_CFG_RST;
         rate_q  <= `TLM_RATE_RST;
         cmask_q <= '0;
         hyst_q  <= `TLM_HYST_RST;
         cons_q  <= `TLM_CONS_RST;
      end
      else if (wr_en)
      begin
         if (hit(address, `TLM_A_CFG))
            cfg_q <= 8'(wmerge({24'h0, cfg_q}, writedata, byteenable));
         if (hit(address, `TLM_A_RATE))
            rate_q <= 4'(wmerge({28'h0, rate_q}, writedata, byteenable));
         if (hit(address, `TLM_A_CMASK))
            cmask_q <= 4'(wmerge({28'h0, cmask_q}, writedata, byteenable));
         if (hit(address, `TLM_A_HYST))
            hyst_q <= 8'(wmerge({24'h0, hyst_q}, writedata, byteenable));
         if (hit(address, `TLM_A_CONS))
            cons_q <= 8'(wmerge({24'h0, cons_q}, writedata, byteenable));
      end
   end

   // Rate timer runs only while active.
   always_ff @(posedge clk)
   begin
      if (srst || stby)
      begin
         tmr_q  <= '0;
         tick_q <= 1'b0;
      end
      else if (tmr_q >= period - 33'd1)
      begin
         tmr_q  <= '0;
         tick_q <= 1'b1;
      end
      else
      begin
         tmr_q  <= tmr_q + 33'd1;
         tick_q <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         os_pend_q <= 1'b0;
      else if (wr_en && hit(address, `TLM_A_ONESHOT) && stby)
         os_pend_q <= 1'b1;
      else if (st_q == tlm_pkg::SEQ_IDLE)
         os_pend_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_q     <= tlm_pkg::SEQ_IDLE;
         ch_q     <= '0;
         os_run_q <= 1'b0;
      end
      else
      begin
         case (st_q)
            tlm_pkg::SEQ_IDLE:
               if ((!stby && tick_q) || (stby && os_pend_q))
               begin
                  ch_q     <= '0;
                  os_run_q <= stby;
                  st_q     <= tlm_pkg::SEQ_START;
               end
            tlm_pkg::SEQ_START:
               st_q <= abort ? tlm_pkg::SEQ_IDLE : tlm_pkg::SEQ_WAIT;
            tlm_pkg::SEQ_WAIT:
               if (conv_done)
                  st_q <= tlm_pkg::SEQ_EVAL;
            tlm_pkg::SEQ_EVAL:
               if (ch_q == 2'(NCH - 1))
               begin
                  os_run_q <= 1'b0;
                  st_q     <= tlm_pkg::SEQ_IDLE;
               end
               else
               begin
                  ch_q <= ch_q + 2'd1;
                  st_q <= tlm_pkg::SEQ_START;
               end
            default:
               st_q <= tlm_pkg::SEQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         conv_start <= 1'b0;
         conv_req   <= '0;
      end
      else
      begin
         conv_start    <= st_q == tlm_pkg::SEQ_START && !abort;
         conv_req.chan <= ch_q;
         conv_req.avg  <= (ch_q == 2'd0) ? avg_code(rate_eff, 1'b1)
                          : avg_code(rate_eff, cfg_q[`TLM_CFG_AVGDIS]);
         conv_req.beta <= cpu_q[ch_q] && ch_q == 2'd1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : gch
         wire        ev   = st_q == tlm_pkg::SEQ_EVAL && ch_q == 2'(g);
         wire [7:0]  t8   = temp_q[g][10:3];
         wire        hi   = t8 >= lim_q[g].high;
         wire        lo   = !flt_q[g] && t8 < lim_q[g].low;
         wire        thm  = t8 >= lim_q[g].therm;
         wire        out  = hi || lo || flt_q[g];
         wire [3:0]  an   = out ? ((acnt_q[g] == 4'hf) ? 4'hf : acnt_q[g] + 4'h1) : 4'h0;
         wire [3:0]  tn   = thm ? ((tcnt_q[g] == 4'hf) ? 4'hf : tcnt_q[g] + 4'h1) : 4'h0;
         wire        clr  = wr_en && hit(address, `TLM_A_STATUS) && byteenable[0];
         assign aq_w[g] = ev && out && an >= alr_need;
         assign hq_w[g] = aq_w[g] && hi;
         assign tq_w[g] = ev && thm && tn >= thm_need;

         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               temp_q[g] <= '0;
               flt_q[g]  <= 1'b0;
               cpu_q[g]  <= 1'b0;
            end
            else if (st_q == tlm_pkg::SEQ_WAIT && conv_done && ch_q == 2'(g))
            begin
               temp_q[g] <= conv_rsp.fault ? 11'h0 : conv_rsp.data;
               flt_q[g]  <= conv_rsp.fault;
               cpu_q[g]  <= conv_rsp.cpu_diode;
            end
         end

         always_ff @(posedge clk)
         begin
            if (srst)
               lim_q[g] <= {`TLM_THERM_RST, `TLM_LOW_RST, `TLM_HIGH_RST};
            else if (wr_en && address == `TLM_A_LIM + 8'(4 * g))
               lim_q[g] <= 24'(wmerge({8'h0, lim_q[g]}, writedata, byteenable));
         end

         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               acnt_q[g]    <= '0;
               tcnt_q[g]    <= '0;
               hi_rel_q[g]  <= 1'b1;
               thm_rel_q[g] <= 1'b1;
            end
            else if (ev)
            begin
               acnt_q[g]    <= an;
               tcnt_q[g]    <= tn;
               hi_rel_q[g]  <= {1'b0, t8} + {1'b0, hyst_q} < {1'b0, lim_q[g].high};
               thm_rel_q[g] <= {1'b0, t8} + {1'b0, hyst_q} < {1'b0, lim_q[g].therm};
            end
         end

         // Hardware set wins over a same-cycle software clear.
         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               hi_st_q[g]  <= 1'b0;
               lo_st_q[g]  <= 1'b0;
               flt_st_q[g] <= 1'b0;
            end
            else
            begin
               if (hq_w[g])
                  hi_st_q[g] <= 1'b1;
               else if (cmp ? !cmp_alert_q : (clr && writedata[g]))
                  hi_st_q[g] <= 1'b0;
               if (aq_w[g] && lo)
                  lo_st_q[g] <= 1'b1;
               else if (clr && writedata[NCH + g])
                  lo_st_q[g] <= 1'b0;
               if (aq_w[g] && flt_q[g])
                  flt_st_q[g] <= 1'b1;
               else if (clr && writedata[2 * NCH + g])
                  flt_st_q[g] <= 1'b0;
            end
         end

         always_ff @(posedge clk)
         begin
            if (srst)
               thm_st_q[g] <= 1'b0;
            else if (tq_w[g])
               thm_st_q[g] <= 1'b1;
            else if (!therm_act_q)
               thm_st_q[g] <= 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (srst)
         therm_act_q <= 1'b0;
      else if (|tq_w)
         therm_act_q <= 1'b1;
      else if (&thm_rel_q)
         therm_act_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst || !cmp)
         cmp_alert_q <= 1'b0;
      else if (|(hq_w & ~cmask_q))
         cmp_alert_q <= 1'b1;
      else if (&(hi_rel_q | cmask_q))
         cmp_alert_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         alert_n_oe  <= 1'b0;
         alert_n_out <= 1'b0;
         therm_n_oe  <= 1'b0;
         therm_n_out <= 1'b0;
      end
      else
      begin
         alert_n_oe <= cmp ? cmp_alert_q
                       : !cfg_q[`TLM_CFG_MASK]
                         && |((hi_st_q | lo_st_q | flt_st_q) & ~cmask_q);
         therm_n_oe <= therm_act_q;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_os_write;
      wr_en && hit(address, `TLM_A_ONESHOT) && stby && st_q == tlm_pkg::SEQ_IDLE;
   endsequence
   sequence s_sweep_start;
      ##[1:3] conv_start;
   endsequence

   AST_RATE_RESET: assert property ($past(srst) |-> rate_q == `TLM_RATE_RST)
      else $error("rate not at 4/sec after reset");
   AST_ONESHOT_ACTIVE: assert property (wr_en && hit(address, `TLM_A_ONESHOT) && !stby
         && st_q != tlm_pkg::SEQ_IDLE |=> !os_pend_q)
      else $error("one-shot took effect while active");
   AST_ONESHOT_RUN: assert property (s_os_write |-> s_sweep_start)
      else $error("one-shot did not start a sweep");
   AST_STANDBY_QUIET: assert property (conv_start |-> $past(!stby || os_run_q))
      else $error("conversion started in standby");
   AST_AVG_4SEC: assert property (conv_start && conv_req.chan != 2'd0
         && $past(rate_q == 4'h6 && !cfg_q[`TLM_CFG_AVGDIS]) |-> conv_req.avg == 3'h4)
      else $error("wrong averaging factor at 4/sec");
   AST_NO_BETA_HI: assert property (conv_start && conv_req.chan >= 2'd2 |-> !conv_req.beta)
      else $error("beta used on anti-parallel channel");
   AST_FAULT_ZERO: assert property (st_q == tlm_pkg::SEQ_WAIT && conv_done && conv_rsp.fault
         |=> temp_q[ch_q] == 11'h0)
      else $error("faulty diode did not read zero");
   AST_THERM_HOLD: assert property (therm_act_q && !(&thm_rel_q) |=> therm_act_q)
      else $error("over-temperature released early");
   AST_THERM_STATUS: assert property ($fell(therm_act_q) |=> thm_st_q == '0)
      else $error("over-temperature status not cleared");
   AST_MASK_ALL: assert property ((!cmp && cfg_q[`TLM_CFG_MASK]) [*2] |-> !alert_n_oe)
      else $error("alert driven while globally masked");
   AST_CMP_ALERT: assert property ((cmp && cmp_alert_q) [*2] |-> alert_n_oe)
      else $error("comparator alert not driven");
endmodule

// ===== bench/conv_model.sv
`timescale 1ns/1ps
// Behavioural converter: answers each start dly+1 cycles after sampling it, with the chosen channel value.
module conv_model
(
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic               conv_start,
   input  wire tlm_pkg::conv_req_s conv_req,
   input  wire logic [43:0]        temps,
   input  wire logic [3:0]         faults,
   input  wire logic               cpu_diode,
   input  wire logic [3:0]         dly,
   output logic                    conv_done,
   output tlm_pkg::conv_rsp_s      conv_rsp
);
   logic [4:0]         cnt_q;
   logic               busy_q;
   tlm_pkg::chan_t     chan_q;
   tlm_pkg::conv_rsp_s last_q;

   // Outside the done pulse the response bus shows the inverse of the last value.
   assign conv_rsp = conv_done ? last_q : ~last_q;

   always_ff @(posedge clk)
   begin
      conv_done <= 1'b0;
      if (srst)
      begin
         busy_q <= 1'b0;
         cnt_q  <= 5'h00;
         chan_q <= 2'h0;
         last_q <= '0;
      end
      else if (conv_start)
      begin
         busy_q <= 1'b1;
         cnt_q  <= {1'b0, dly};
         chan_q <= conv_req.chan;
      end
      else if (busy_q && cnt_q != 5'h00)
      begin
         cnt_q <= cnt_q - 5'h01;
      end
      else if (busy_q)
      begin
         busy_q           <= 1'b0;
         conv_done        <= 1'b1;
         last_q.data      <= faults[chan_q] ? 11'h000 : temps[int'(chan_q) * 11 +: 11];
         last_q.fault     <= faults[chan_q];
         last_q.cpu_diode <= cpu_diode;
      end
   end
endmodule

// ===== bench/test_temp_limit_alert_monitor.sv
`timescale 1ns/1ps
`include "tlm_cfg.svh"
module test_temp_limit_alert_monitor;
   typedef struct packed
   {
      logic [7:0]  addr;
      logic [31:0] exp;
   } row_s;
   logic               clk = 1'b0;
   logic               srst = 1'b1;
   logic [7:0]         address = 8'h00;
   logic               read = 1'b0;
   logic               write = 1'b0;
   logic [31:0]        writedata = 32'h0;
   logic [31:0]        readdata;
   logic               waitrequest;
   logic               conv_start;
   tlm_pkg::conv_req_s conv_req;
   logic               conv_done;
   tlm_pkg::conv_rsp_s conv_rsp;
   logic               alert_n_out;
   logic               alert_n_oe;
   logic               therm_n_out;
   logic               therm_n_oe;
   logic [43:0]        temps = 44'h0;
   logic [3:0]         faults = 4'h0;
   logic               cpu_diode = 1'b1;
   logic [3:0]         dly = 4'h0;
   logic [2:0]         avg_seen [4];
   logic [3:0]         beta_seen;
   int                 n_starts = 0;
   int                 err_total = 0;
   int                 n_checks = 0;
   logic [31:0]        s;
   row_s               rows [10];

   always #2.5 clk = ~clk;

   temp_limit_alert_monitor #(.FAST_PERIOD_CYC(50)) temp_limit_alert_monitor_i
   (
      .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
      .waitrequest(waitrequest), .conv_start(conv_start), .conv_req(conv_req),
      .conv_done(conv_done), .conv_rsp(conv_rsp), .alert_n_out(alert_n_out),
      .alert_n_oe(alert_n_oe), .therm_n_out(therm_n_out), .therm_n_oe(therm_n_oe)
   );

   conv_model conv_model_i
   (
      .clk(clk), .srst(srst), .conv_start(conv_start), .conv_req(conv_req),
      .temps(temps), .faults(faults), .cpu_diode(cpu_diode), .dly(dly),
      .conv_done(conv_done), .conv_rsp(conv_rsp)
   );

   always @(posedge clk)
   begin
      if (conv_start === 1'b1)
      begin
         n_starts <= n_starts + 1;
         avg_seen[conv_req.chan] <= conv_req.avg;
         beta_seen[conv_req.chan] <= conv_req.beta;
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      address   <= a;
      writedata <= d;
      write     <= wr;
      read      <= ~wr;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 40);
      if (n >= 40)
         chk("bus answer", 32'h0, 32'h1);
      q = readdata;
      write <= 1'b0;
      read  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask

   task automatic sweep();
      logic [31:0] q;
      wr(`TLM_A_ONESHOT, 32'h1);
      repeat (3) @(posedge clk);
      for (int i = 0; i < 100; i++)
      begin
         rd(`TLM_A_STATUS, q);
         if (q[16] === 1'b0)
            break;
      end
      repeat (4) @(posedge clk);
   endtask

   task automatic pins(input logic a, input logic t);
      chk("alert_n_oe", {31'h0, a}, {31'h0, alert_n_oe});
      chk("therm_n_oe", {31'h0, t}, {31'h0, therm_n_oe});
   endtask

   function automatic logic [2:0] exp_avg(input int r, input logic dis);
      if (dis && r <= 7)
         return 3'h3;
      return (r <= 3) ? 3'h7 : 3'(10 - r);
   endfunction

   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge clk);
      err_total++;
      close_out();
   end

   initial
   begin
      rows = '{'{`TLM_A_CFG, 32'h0}, '{`TLM_A_RATE, 32'h6}, '{`TLM_A_CMASK, 32'h0},
               '{`TLM_A_HYST, 32'h0a}, '{`TLM_A_CONS, 32'h11}, '{`TLM_A_STATUS, 32'h0},
               '{`TLM_A_LIM, 32'h550055}, '{8'h3c, 32'h550055}, '{`TLM_A_TEMP, 32'h0},
               '{8'h40, 32'h0}};
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      pins(1'b0, 1'b0);
      chk("waitrequest", 32'h1, {31'h0, waitrequest});
      foreach (rows[i])
      begin
         rd(rows[i].addr, s);
         chk("reset value", rows[i].exp, s);
      end
      wr(`TLM_A_CFG, 32'h1);
      repeat (20) @(posedge clk);
      n_starts <= 0;
      repeat (2000) @(posedge clk);
      chk("standby starts", 32'h0, 32'(n_starts));
      sweep();
      chk("one-shot starts", 32'h4, 32'(n_starts));
      for (int d = 0; d < 2; d++)
      begin
         for (int r = 0; r <= 10; r++)
         begin
            dly <= r[0] ? 4'h9 : 4'h0;
            wr(`TLM_A_CFG, d ? 32'h9 : 32'h1);
            wr(`TLM_A_RATE, 32'(r));
            sweep();
            chk("avg factor", {29'h0, exp_avg(r, d[0])}, {29'h0, avg_seen[1]});
         end
      end
      chk("beta", 32'h2, {28'h0, beta_seen});
      wr(`TLM_A_CFG, 32'h1);
      wr(`TLM_A_RATE, 32'h6);
      temps <= {11'h7ff, 11'h100, 11'h155, 11'h2ab};
      faults <= 4'h4;
      sweep();
      chk("avg one-shot", 32'h4, {29'h0, avg_seen[1]});
      rd(`TLM_A_TEMP, s);
      chk("temp ch0", 32'h5560, s);
      rd(8'h28, s);
      chk("temp fault", 32'h0, s);
      rd(`TLM_A_STATUS, s);
      chk("status", 32'h9409, s);
      pins(1'b1, 1'b1);
      chk("alert_n_out", 32'h0, {31'h0, alert_n_out});
      temps <= {11'h100, 11'h100, 11'h100, 11'h258};
      faults <= 4'h0;
      sweep();
      rd(`TLM_A_STATUS, s);
      rd(`TLM_A_STATUS, s);
      chk("therm status", 32'h1, {31'h0, s[12]});
      pins(1'b1, 1'b1);
      temps[10:0] <= 11'h248;
      sweep();
      rd(`TLM_A_STATUS, s);
      chk("therm clear", 32'h0, {28'h0, s[15:12]});
      pins(1'b1, 1'b0);
      wr(`TLM_A_STATUS, 32'hfff);
      rd(`TLM_A_STATUS, s);
      chk("status clear", 32'h0, s);
      pins(1'b0, 1'b0);
      wr(8'h34, 32'h7f0055);
      temps[21:11] <= 11'h300;
      sweep();
      wr(`TLM_A_CFG, 32'h5);
      wr(`TLM_A_STATUS, 32'hfff);
      sweep();
      rd(`TLM_A_STATUS, s);
      chk("masked status", 32'h2, s);
      pins(1'b0, 1'b0);
      wr(`TLM_A_CFG, 32'h1);
      repeat (4) @(posedge clk);
      pins(1'b1, 1'b0);
      wr(`TLM_A_CMASK, 32'h2);
      wr(`TLM_A_STATUS, 32'hfff);
      sweep();
      rd(`TLM_A_STATUS, s);
      chk("chan mask status", 32'h2, s);
      pins(1'b0, 1'b0);
      wr(`TLM_A_CMASK, 32'h0);
      wr(`TLM_A_CFG, 32'h7);
      wr(`TLM_A_STATUS, 32'hfff);
      sweep();
      pins(1'b1, 1'b0);
      temps[21:11] <= 11'h258;
      sweep();
      rd(`TLM_A_STATUS, s);
      chk("cmp hold status", 32'h1, {31'h0, s[1]});
      pins(1'b1, 1'b0);
      temps[21:11] <= 11'h248;
      sweep();
      rd(`TLM_A_STATUS, s);
      chk("cmp release status", 32'h0, {31'h0, s[1]});
      pins(1'b0, 1'b0);
      wr(`TLM_A_CMASK, 32'h2);
      temps[21:11] <= 11'h300;
      sweep();
      pins(1'b0, 1'b0);
      wr(`TLM_A_CMASK, 32'h0);
      wr(`TLM_A_RATE, 32'ha);
      wr(`TLM_A_CFG, 32'h0);
      n_starts <= 0;
      repeat (1000) @(posedge clk);
      chk("active sweeps", 32'h1, {31'h0, n_starts >= 40});
      close_out();
   end
endmodule
